// ==== design/sram_host_pkg.sv ====
// constants for the asynchronous static memory host controller
package sram_host_pkg;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    // times in their own units, as printed
    localparam int T_POWER_US = 100;
    localparam int T_RECOVER_NS = 10;
    localparam int T_ACCESS_NS = 10;
    localparam int T_WR_SETUP_NS = 7;
    localparam int T_DATA_SETUP_NS = 5;
    localparam int T_BUS_RELEASE_NS = 5;
    localparam int T_DESELECT_LEAD_NS = 0;
    // least times round up, never below one cycle
    function automatic int min_cycles(input longint t_ps);
        longint c;
        c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : int'(c);
    endfunction
    localparam int POWER_CYC = min_cycles(longint'(T_POWER_US) * 1000000);
    localparam int RECOVER_CYC = min_cycles(longint'(T_RECOVER_NS) * 1000);
    localparam int ACCESS_CYC = min_cycles(longint'(T_ACCESS_NS) * 1000);
    localparam int WR_SETUP_CYC = min_cycles(longint'(T_WR_SETUP_NS) * 1000);
    localparam int DATA_SETUP_CYC = min_cycles(longint'(T_DATA_SETUP_NS) * 1000);
    localparam int RELEASE_CYC = min_cycles(longint'(T_BUS_RELEASE_NS) * 1000);
    localparam int LEAD_CYC = min_cycles(longint'(T_DESELECT_LEAD_NS) * 1000);
    localparam int CNT_W = 13;
    typedef enum logic [2:0] {ST_POWERUP, ST_IDLE, ST_RD, ST_WR_REL, ST_WR, ST_WR_END,
                              ST_RETAIN, ST_RECOVER} state_t;
endpackage

// ==== design/sram_pin_sync.sv ====
// two-flop synchroniser bank for pins coming back from the memory
`timescale 1ns/100ps
module sram_pin_sync
    import sram_host_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    // first stage is read by the second stage only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // sram_pin_sync

// ==== design/sram_host_ctrl.sv ====
// host-side controller driving a 1M x 16 asynchronous static memory with error flag
`timescale 1ns/100ps
module sram_host_ctrl
    import sram_host_pkg::*;
#(
    parameter int POWER_CYCLES = POWER_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // user request side
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic [DATA_W-1:0] REQ_WDATA,
    input wire logic [1:0] REQ_LANES,
    input wire logic RETAIN_REQ,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [DATA_W-1:0] RSP_RDATA,
    output logic RSP_CORRECTED,
    output logic RETAIN_ACK,
    // memory pins
    output logic CHIP_SEL_N,
    output logic WRITE_STROBE_N,
    output logic OUT_ENABLE_N,
    output logic UPPER_LANE_ENABLE_N,
    output logic LOWER_LANE_ENABLE_N,
    output logic [ADDR_W-1:0] WORD_ADDRESS,
    input wire logic [DATA_W-1:0] DATA_LINES_IN,
    output logic [DATA_W-1:0] DATA_LINES_OUT,
    output logic DATA_LINES_OE_N,
    input wire logic ERR_FLAG_IN
);
    // ------------------------------------------------------------
    // synchronised pin inputs
    // ------------------------------------------------------------
    logic [DATA_W:0] pins_s;
    sram_pin_sync #(.W(DATA_W + 1)) u_sync (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .d({ERR_FLAG_IN, DATA_LINES_IN}),
        .q(pins_s)
    );

    // ------------------------------------------------------------
    // state and counters
    // ------------------------------------------------------------
    state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    // lanes of the request in flight, bit1 upper, bit0 lower
    logic [1:0] lanes_r;
    // two sync stages after the access time so the sample is settled
    localparam logic [CNT_W-1:0] RD_WAIT = CNT_W'(ACCESS_CYC + 2);
    localparam logic [CNT_W-1:0] WR_WAIT = CNT_W'((WR_SETUP_CYC > DATA_SETUP_CYC)
                                                  ? WR_SETUP_CYC : DATA_SETUP_CYC);
    localparam logic [CNT_W-1:0] REL_WAIT = CNT_W'(RELEASE_CYC);
    localparam logic [CNT_W-1:0] REC_WAIT = CNT_W'(RECOVER_CYC);
    localparam logic [CNT_W-1:0] LEAD_WAIT = CNT_W'(LEAD_CYC);

    wire cnt_done = (cnt_r == '0);
    wire take = (state_r == ST_IDLE) && REQ_VALID && (REQ_LANES != 2'b00);

    // ------------------------------------------------------------
    // next-state decode
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_done ? cnt_r : cnt_r - 1'b1;
        unique case (state_r)
            ST_POWERUP: begin
                if (cnt_done) state_nxt = ST_IDLE;
            end
            ST_IDLE: begin
                if (RETAIN_REQ) begin
                    state_nxt = ST_RETAIN;
                    cnt_nxt = LEAD_WAIT;
                end else if (take && REQ_WRITE) begin
                    state_nxt = ST_WR_REL;
                    cnt_nxt = REL_WAIT;
                end else if (take) begin
                    state_nxt = ST_RD;
                    cnt_nxt = RD_WAIT;
                end
            end
            ST_RD: begin
                if (cnt_done) state_nxt = ST_IDLE;
            end
            ST_WR_REL: begin
                if (cnt_done) begin
                    state_nxt = ST_WR;
                    cnt_nxt = WR_WAIT;
                end
            end
            ST_WR: begin
                if (cnt_done) state_nxt = ST_WR_END;
            end
            ST_WR_END: state_nxt = ST_IDLE;
            ST_RETAIN: begin
                if (!RETAIN_REQ && cnt_done) begin
                    state_nxt = ST_RECOVER;
                    cnt_nxt = REC_WAIT;
                end
            end
            ST_RECOVER: begin
                if (cnt_done) state_nxt = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= ST_POWERUP;
            cnt_r <= CNT_W'(POWER_CYCLES);
            lanes_r <= 2'b00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (take) begin
                lanes_r <= REQ_LANES;
            end
        end
    end

    // ------------------------------------------------------------
    // pin registers; all memory pins come straight from flops
    // ------------------------------------------------------------
    wire sel = (state_nxt == ST_RD) || (state_nxt == ST_WR_REL) || (state_nxt == ST_WR);
    wire strobe = (state_nxt == ST_WR);
    wire drive = (state_nxt == ST_WR) || (state_nxt == ST_WR_END);
    wire rd_pin = (state_nxt == ST_RD);
    wire [1:0] lanes_nxt = take ? REQ_LANES : lanes_r;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            CHIP_SEL_N <= 1'b1;
            WRITE_STROBE_N <= 1'b1;
            OUT_ENABLE_N <= 1'b1;
            UPPER_LANE_ENABLE_N <= 1'b1;
            LOWER_LANE_ENABLE_N <= 1'b1;
            WORD_ADDRESS <= '0;
            DATA_LINES_OUT <= '0;
            DATA_LINES_OE_N <= 1'b1;
        end else begin
            CHIP_SEL_N <= !sel;
            WRITE_STROBE_N <= !strobe;
            OUT_ENABLE_N <= !rd_pin;
            UPPER_LANE_ENABLE_N <= !(sel && lanes_nxt[1]);
            LOWER_LANE_ENABLE_N <= !(sel && lanes_nxt[0]);
            if (take) begin
                WORD_ADDRESS <= REQ_ADDR;
                DATA_LINES_OUT <= REQ_WDATA;
            end
            DATA_LINES_OE_N <= !drive;
        end
    end

    // ------------------------------------------------------------
    // answer side; flag only counts while a read is on the pins
    // ------------------------------------------------------------
    wire rd_done = (state_r == ST_RD) && cnt_done;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= '0;
            RSP_CORRECTED <= 1'b0;
            RETAIN_ACK <= 1'b0;
        end else begin
            REQ_READY <= (state_nxt == ST_IDLE) && !take;
            RSP_VALID <= rd_done;
            if (rd_done) begin
                // unselected lanes read zero: they float on the bus
                RSP_RDATA <= {lanes_r[1] ? pins_s[DATA_W-1:LANE_W] : 8'h00,
                              lanes_r[0] ? pins_s[LANE_W-1:0] : 8'h00};
                RSP_CORRECTED <= pins_s[DATA_W];
            end
            RETAIN_ACK <= (state_nxt == ST_RETAIN);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_idle_deselect;
        @(posedge CLK_SYS) disable iff (!RSTN)
        (state_r == ST_IDLE) |-> CHIP_SEL_N;
    endproperty
    a_idle_deselect: assert property (p_idle_deselect) else $error("selected while idle");

    property p_no_contention;
        @(posedge CLK_SYS) disable iff (!RSTN)
        !DATA_LINES_OE_N |-> (OUT_ENABLE_N && $past(OUT_ENABLE_N));
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("bus contention");

    property p_strobe_width;
        @(posedge CLK_SYS) disable iff (!RSTN)
        $fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N [*1] ##1 !DATA_LINES_OE_N;
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("short write");

    property p_data_hold;
        @(posedge CLK_SYS) disable iff (!RSTN)
        $rose(WRITE_STROBE_N) |-> !DATA_LINES_OE_N && $stable(WORD_ADDRESS);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("write hold lost");

    property p_write_lane;
        @(posedge CLK_SYS) disable iff (!RSTN)
        !WRITE_STROBE_N |-> !CHIP_SEL_N && !(UPPER_LANE_ENABLE_N && LOWER_LANE_ENABLE_N);
    endproperty
    a_write_lane: assert property (p_write_lane) else $error("write without lane");

    property p_power_wait;
        @(posedge CLK_SYS) disable iff (!RSTN)
        (state_r == ST_POWERUP) |-> CHIP_SEL_N;
    endproperty
    a_power_wait: assert property (p_power_wait) else $error("early access");

    property p_read_strobe;
        @(posedge CLK_SYS) disable iff (!RSTN)
        !OUT_ENABLE_N |-> WRITE_STROBE_N && !CHIP_SEL_N;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("bad read pins");

    property p_read_resp;
        @(posedge CLK_SYS) disable iff (!RSTN)
        $fell(OUT_ENABLE_N) |-> ##[4:8] RSP_VALID;
    endproperty
    a_read_resp: assert property (p_read_resp) else $error("read answer late");

    property p_retain_quiet;
        @(posedge CLK_SYS) disable iff (!RSTN)
        RETAIN_ACK |-> CHIP_SEL_N;
    endproperty
    a_retain_quiet: assert property (p_retain_quiet) else $error("access in retention");
endmodule // sram_host_ctrl

// ==== bench/sram_partner.sv ====
// behavioural asynchronous static memory with single-bit error flag
`timescale 1ns/100ps
module sram_partner
    import sram_host_pkg::*;
(
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic ub_n,
    input wire logic lb_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] host_d,
    input wire logic host_oe_n,
    input wire logic [ADDR_W-1:0] err_addr,
    output logic [DATA_W-1:0] data_in,
    output logic err_out,
    output logic clash
);
    // ------------------------------------------------------------
    // array and mode decode
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] rd_d, lat_d;
    logic [DATA_W-1:0] last_d = '0;
    logic [1:0] lat_m;
    logic last_e = 1'b0;
    wire rd_on = !cs_n && !oe_n && we_n && !(ub_n && lb_n);
    wire wr_on = !cs_n && !we_n && !(ub_n && lb_n);
    initial clash = 1'b0;
    // floating lanes show the inverse of the last value so a stale read cannot pass
    always @* begin
        rd_d = mem.exists(int'(addr)) ? mem[int'(addr)] : '0;
        if (rd_on) last_d = rd_d;
        if (rd_on) last_e = (addr == err_addr);
        data_in[15:8] = (rd_on && !ub_n) ? rd_d[15:8] : ~last_d[15:8];
        data_in[7:0] = (rd_on && !lb_n) ? rd_d[7:0] : ~last_d[7:0];
        err_out = rd_on ? (addr == err_addr) : ~last_e;
    end
    // data and lanes are taken as they stand when the write ends
    always @* begin
        if (wr_on) lat_d = host_d;
        if (wr_on) lat_m = {!ub_n, !lb_n};
    end
    always @(negedge wr_on) begin
        mem[int'(addr)] = (mem.exists(int'(addr)) ? mem[int'(addr)] : '0)
            & ~{{8{lat_m[1]}}, {8{lat_m[0]}}} | (lat_d & {{8{lat_m[1]}}, {8{lat_m[0]}}});
    end
    // both sides driving after the glitch window is a contention
    always @(rd_on or host_oe_n) #1 if (rd_on && !host_oe_n) clash = 1'b1;
endmodule // sram_partner

// ==== bench/async_sram_ecc_byte_port_test.sv ====
// self-checking bench for the static memory host controller
`timescale 1ns/100ps
module async_sram_ecc_byte_port_test
    import sram_host_pkg::*;
;
    logic clk, rstn, req_valid, req_write, retain_req;
    logic [ADDR_W-1:0] req_addr, a;
    logic [ADDR_W-1:0] err_addr = 20'h00005;
    logic [DATA_W-1:0] req_wdata;
    logic [1:0] req_lanes, ln;
    logic w;
    // flags the wait task watches by reference must be variables
    logic req_ready, rsp_valid, retain_ack;
    wire rsp_corrected, cs_n, we_n, oe_n, ub_n, lb_n;
    wire dl_oe_n, err_in, clash;
    wire [ADDR_W-1:0] waddr;
    wire [DATA_W-1:0] dl_in, dl_out, rsp_rdata;
    logic [DATA_W-1:0] ref_mem [int];
    int n_mismatch = 0, checks_done = 0, seed = 32'hc8aa, i, k, bad;

    sram_host_ctrl #(.POWER_CYCLES(10)) dut_u (.CLK_SYS(clk), .RSTN(rstn),
        .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
        .REQ_WDATA(req_wdata), .REQ_LANES(req_lanes), .RETAIN_REQ(retain_req),
        .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
        .RSP_CORRECTED(rsp_corrected), .RETAIN_ACK(retain_ack), .CHIP_SEL_N(cs_n),
        .WRITE_STROBE_N(we_n), .OUT_ENABLE_N(oe_n), .UPPER_LANE_ENABLE_N(ub_n),
        .LOWER_LANE_ENABLE_N(lb_n), .WORD_ADDRESS(waddr), .DATA_LINES_IN(dl_in),
        .DATA_LINES_OUT(dl_out), .DATA_LINES_OE_N(dl_oe_n), .ERR_FLAG_IN(err_in));
    sram_partner mem_u (.cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .ub_n(ub_n), .lb_n(lb_n),
        .addr(waddr), .host_d(dl_out), .host_oe_n(dl_oe_n), .err_addr(err_addr),
        .data_in(dl_in), .err_out(err_in), .clash(clash));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // edges until a flag is seen high, bounded so a hang reads as a mismatch
    task automatic wait_hi(ref logic f, input int lim);
        i = 0;
        do begin @(posedge clk); i++; end while (f !== 1'b1 && i < lim);
    endtask
    // one request held until taken; reads compared with the bench model
    task access(input logic wr, input logic [19:0] ad, input logic [15:0] d, input logic [1:0] l);
        logic [15:0] m;
        m = {{8{l[1]}}, {8{l[0]}}};
        @(posedge clk);
        req_valid <= 1'b1; req_write <= wr; req_addr <= ad; req_wdata <= d; req_lanes <= l;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        if (wr) begin
            ref_mem[ad] = ((ref_mem.exists(ad) ? ref_mem[ad] : 16'h0) & ~m) | (d & m);
            wait_hi(req_ready, 20);
        end else begin
            wait_hi(rsp_valid, 20);
            check(rsp_rdata, (ref_mem.exists(ad) ? ref_mem[ad] : 16'h0) & m);
            check(rsp_corrected, ad == err_addr);
        end
        check(i < 20, 1'b1);
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #500000;
        n_mismatch++;
        final_report;
    end
    initial begin
        rstn = 1'b0; req_valid = 1'b0; req_write = 1'b0; retain_req = 1'b0;
        req_addr = '0; req_wdata = '0; req_lanes = 2'h0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        wait_hi(req_ready, 100);
        check(i >= 10 && i < 100, 1'b1);
        // small address space so partial lane writes overlap and get read back
        for (k = 0; k < 60; k++) begin
            a = {16'h0, 4'($random(seed))};
            ln = 2'($random(seed));
            if (ln == 2'h0) ln = 2'h3;
            w = (k < 16) ? 1'b1 : 1'($random(seed));
            access(w, a, 16'($random(seed)), ln);
        end
        access(1'b1, 20'hfffff, 16'ha5c3, 2'h3);
        access(1'b0, 20'hfffff, 16'h0, 2'h2);
        access(1'b0, err_addr, 16'h0, 2'h3);
        // a request with no lanes must not select the memory
        @(posedge clk);
        req_valid <= 1'b1; req_lanes <= 2'h0;
        bad = 0;
        repeat (8) begin @(posedge clk); if (cs_n !== 1'b1) bad++; end
        check(bad, 0);
        req_valid <= 1'b0;
        // retention: deselect first, then resume after recovery
        @(posedge clk);
        retain_req <= 1'b1;
        wait_hi(retain_ack, 20);
        check(retain_ack, 1'b1);
        check(cs_n, 1'b1);
        retain_req <= 1'b0;
        wait_hi(req_ready, 20);
        check(i > RECOVER_CYC && i < 20, 1'b1);
        access(1'b0, 20'hfffff, 16'h0, 2'h3);
        check(clash, 1'b0);
        final_report;
    end
endmodule // async_sram_ecc_byte_port_test
